// ===== src/cfc_fault_confinement.sv
// fault confinement: error frames, error counters, states, bus-off recovery
// Summary of operation
// R1: sleep wakes on bus activity, stop never
// R2: compare driven and sampled levels, flag mismatch
// R3: receiver detects stuff, crc and form errors
// R4: transmitter flags recessive acknowledge slot
// R5: error frame immediately; crc after ack delimiter
// R6: retransmit after error unless single shot
// R7: counter at 96 sets warning flag
// R8: counter at 128 sets passive flag
// R9: transmit count reaching 256 means bus-off
// R10: active flag dominant, passive recessive, suspend
// R11: receiver adds one, or eight on dominant
// R12: transmitter error flag adds eight, two exceptions
// R13: bit error during own flag adds eight
// R14: long dominant runs after flags add eight
// R15: good transmission decrements transmit count
// R16: good reception decrements or reloads receive count
// R17: bus-off holds output recessive, no storing
// R18: recovery waits 128 runs of 11 recessive
// R19: recovery runs counted in receive counter field
// R20: no init during sleep/stop; wake recovers
// R21: clear bit with start skips recovery wait
// R22: clear bit resets counters only in init
// R23: reset clears counters and all status
`timescale 1ns/10ps
`default_nettype none
`include "cfc_defines.svh"
module cfc_fault_confinement (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            bit_tick,
  input  wire logic            bus_rx,
  input  wire logic            drv_bit,
  input  wire logic            is_tx,
  input  wire logic            in_arb,
  input  wire logic            in_frame,
  input  wire logic            stuff_zone,
  input  wire logic            crc_chk,
  input  wire logic            crc_ok,
  input  wire logic            form_chk,
  input  wire logic            ack_slot,
  input  wire logic            ack_delim,
  input  wire logic            arb_stuff_bit,
  input  wire logic            ovl_start,
  input  wire logic            tx_ok,
  input  wire logic            rx_ok,
  input  wire logic            single_shot,
  input  wire logic            init_req,
  input  wire logic            op_req,
  input  wire logic            counter_clear_request,
  input  wire cfc_pkg::cfc_ps_t power_save_mode_select,
  output logic                 tx_line_output,
  output logic                 err_frame_start,
  output logic                 retransmit_req,
  output logic                 wake_event,
  output logic                 rx_store_enable,
  output logic                 operating_mode_status,
  output logic                 bus_off_flag,
  output logic                 tx_warning_flag,
  output logic                 tx_passive_flag,
  output logic                 rx_warning_flag,
  output logic                 rx_passive_flag,
  output logic                 rx_passive_indicator,
  output logic [7:0]           tx_fault_counter,
  output logic [7:0]           rx_fault_counter
);
  cfc_pkg::cfc_efs_t st_r;
  cfc_pkg::cfc_efs_t st_nxt;
  logic [7:0] tec_r;
  logic [7:0] tec_nxt;
  logic [7:0] rec_r;
  logic [7:0] rec_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       bus_off_flag_r;
  logic       bus_off_flag_nxt;
  logic       op_r;
  logic       pend_r;
  logic       join_r;
  logic       crc_pend_r;
  logic       flag_act_r;
  logic       fail_tx_r;
  logic       tx_r;
  logic       ackp_r;
  logic       dom_seen_r;
  logic       first_r;
  logic       prev_rx_r;
  logic       bit_err;
  logic       stuff_err;
  logic       crc_err;
  logic       form_err;
  logic       ack_err;
  logic       run_pulse;
  logic       passive;
  logic       active_ok;
  logic       start_err;
  logic       start_ovl;
  logic       tx8;
  logic       rx8;
  logic       rx1;
  logic       dom_hit;
  logic       cc_clear;
  logic       forced;
  logic       init_ok;
  logic       recov_step;
  logic       recov_done;
  logic       wake_now;
  logic       retx_nxt;

  cfc_err_detect u_det (
    .clk        (clk),
    .srst       (srst),
    .bit_tick   (bit_tick),
    .bus_rx     (bus_rx),
    .drv_bit    (drv_bit),
    .is_tx      (is_tx),
    .in_arb     (in_arb),
    .in_frame   (in_frame),
    .stuff_zone (stuff_zone),
    .crc_chk    (crc_chk),
    .crc_ok     (crc_ok),
    .form_chk   (form_chk),
    .ack_slot   (ack_slot),
    .bit_err    (bit_err),
    .stuff_err  (stuff_err),
    .crc_err    (crc_err),
    .form_err   (form_err),
    .ack_err    (ack_err)
  );

  cfc_run_detect u_run (
    .clk       (clk),
    .srst      (srst),
    .bit_tick  (bit_tick),
    .bus_rx    (bus_rx),
    .run_pulse (run_pulse)
  );

  // flag style follows counters as they stood before the error
  assign passive   = (tec_r >= `CFC_PASS_LVL) | rec_r[7]; // R8
  assign active_ok = op_r & ~join_r & ~bus_off_flag_r
                   & (power_save_mode_select == cfc_pkg::CFC_PS_NONE);
  assign start_err = active_ok & (st_r == cfc_pkg::CFC_IDLE)
                   & (bit_err | stuff_err | form_err | ack_err
                   | (bit_tick & ack_delim & crc_pend_r)); // R5
  assign start_ovl = active_ok & bit_tick & ovl_start
                   & (st_r == cfc_pkg::CFC_IDLE);
  assign dom_hit   = bit_tick & (st_r == cfc_pkg::CFC_DOMW) & ~bus_rx
                   & (cnt_r + 5'h01 == (flag_act_r ? `CFC_DOM_ACT
                                                   : `CFC_DOM_STEP)); // R14

  // exceptions: passive ack error without dominant, arbitration stuff bit
  assign tx8 = (start_err & is_tx & ~(ack_err & passive)
             & ~(stuff_err & arb_stuff_bit))
             | (bit_tick & st_r == cfc_pkg::CFC_FLAG & cnt_r == `CFC_FLAG_LAST
               & ackp_r & (dom_seen_r | ~bus_rx))
             | (bit_tick & st_r == cfc_pkg::CFC_FLAG & flag_act_r & bus_rx
               & tx_r)
             | (dom_hit & tx_r); // R12 R13 R14
  assign rx8 = ~rec_r[7] & ~tx_r & ((bit_tick & st_r == cfc_pkg::CFC_FLAG
             & flag_act_r & bus_rx)
             | (bit_tick & st_r == cfc_pkg::CFC_DOMW & first_r & ~bus_rx)
             | dom_hit); // R11 R13 R14
  assign rx1 = start_err & ~is_tx & ~rec_r[7]; // R11

  assign init_ok    = init_req
                    & (power_save_mode_select == cfc_pkg::CFC_PS_NONE); // R20
  assign cc_clear   = counter_clear_request & ~op_r; // R22
  assign forced     = cc_clear & op_req & ~init_req; // R21
  assign recov_step = bus_off_flag_r & pend_r & run_pulse; // R19
  assign recov_done = recov_step & (rec_r == `CFC_RECOV_LAST); // R18
  assign wake_now   = (power_save_mode_select == cfc_pkg::CFC_PS_SLEEP)
                    & bit_tick & prev_rx_r & ~bus_rx; // R1

  always_comb begin
    tec_nxt  = tec_r;
    bus_off_flag_nxt = bus_off_flag_r;
    if (cc_clear || recov_done) begin
      tec_nxt  = 8'h00;
      bus_off_flag_nxt = 1'b0;
    end else if (tx8 && !bus_off_flag_r) begin
      if (tec_r >= `CFC_BUS_OFF_FLAG_MIN) begin
        bus_off_flag_nxt = 1'b1; // R9
      end else begin
        tec_nxt = tec_r + `CFC_INC8;
      end
    end else if (tx_ok && active_ok && tec_r != 8'h00) begin
      tec_nxt = tec_r - 8'h01; // R15
    end
  end

  always_comb begin
    rec_nxt = rec_r;
    if (cc_clear || recov_done) begin
      rec_nxt = 8'h00;
    end else if ((op_req && !op_r && bus_off_flag_r) || (wake_now && bus_off_flag_r)) begin
      rec_nxt = 8'h00; // R19
    end else if (recov_step) begin
      rec_nxt = rec_r + 8'h01; // R19
    end else if (bus_off_flag_r) begin
      rec_nxt = rec_r;
    end else if (rx8) begin
      rec_nxt = rec_r + `CFC_INC8;
    end else if (rx1) begin
      rec_nxt = rec_r + 8'h01;
    end else if (rx_ok && active_ok) begin
      if (rec_r[7]) begin
        rec_nxt = `CFC_REC_LOAD; // R16
      end else if (rec_r != 8'h00) begin
        rec_nxt = rec_r - 8'h01; // R16
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tec_r  <= 8'h00;
      rec_r  <= 8'h00;
      bus_off_flag_r <= 1'b0; // R23
    end else begin
      tec_r  <= tec_nxt;
      rec_r  <= rec_nxt;
      bus_off_flag_r <= bus_off_flag_nxt;
    end
  end

  // status mirrors the next counter values so flags and counts agree
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_fault_counter     <= 8'h00;
      rx_fault_counter     <= 8'h00;
      bus_off_flag         <= 1'b0;
      tx_warning_flag      <= 1'b0;
      tx_passive_flag      <= 1'b0;
      rx_warning_flag      <= 1'b0;
      rx_passive_flag      <= 1'b0;
      rx_passive_indicator <= 1'b0;
      rx_store_enable      <= 1'b1; // R23
    end else begin
      tx_fault_counter     <= tec_nxt;
      rx_fault_counter     <= rec_nxt;
      bus_off_flag         <= bus_off_flag_nxt; // R19
      tx_warning_flag      <= bus_off_flag_nxt | (tec_nxt >= `CFC_WARN_LVL); // R7
      tx_passive_flag      <= bus_off_flag_nxt | (tec_nxt >= `CFC_PASS_LVL); // R8
      rx_warning_flag      <= ~bus_off_flag_nxt & (rec_nxt >= `CFC_WARN_LVL); // R7
      rx_passive_flag      <= ~bus_off_flag_nxt & rec_nxt[7]; // R8
      rx_passive_indicator <= ~bus_off_flag_nxt & rec_nxt[7];
      rx_store_enable      <= ~bus_off_flag_nxt; // R17
    end
  end

  // operating mode, recovery pending and bus join
  always_ff @(posedge clk) begin
    if (srst) begin
      op_r   <= 1'b0;
      pend_r <= 1'b0;
      join_r <= 1'b0;
    end else begin
      if (init_ok) begin
        op_r   <= 1'b0; // R18
        pend_r <= 1'b0;
      end else if (forced) begin
        op_r   <= 1'b1; // R21
        join_r <= 1'b1;
        pend_r <= 1'b0;
      end else if (recov_done) begin
        // completion wins over a late request, which would else stall
        op_r   <= 1'b1; // R18
        pend_r <= 1'b0;
      end else if (op_req && !op_r) begin
        op_r   <= ~bus_off_flag_r;
        pend_r <= bus_off_flag_r; // R18
      end else if (wake_now && bus_off_flag_r) begin
        op_r   <= 1'b0;
        pend_r <= 1'b1; // R20
      end
      if (join_r && run_pulse && !forced) begin
        join_r <= 1'b0; // R21
      end
    end
  end

  // error frame sequencer, advanced once per sampled bit
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    if (bit_tick) begin
      unique case (st_r)
        cfc_pkg::CFC_IDLE: begin
          if (start_err || start_ovl) begin
            st_nxt  = cfc_pkg::CFC_FLAG;
            cnt_nxt = 5'h00;
          end
        end
        cfc_pkg::CFC_FLAG: begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == `CFC_FLAG_LAST) begin
            st_nxt  = cfc_pkg::CFC_DOMW;
            cnt_nxt = 5'h00;
          end
        end
        cfc_pkg::CFC_DOMW: begin
          if (bus_rx) begin
            st_nxt  = cfc_pkg::CFC_DELIM;
            cnt_nxt = 5'h00;
          end else if (dom_hit) begin
            cnt_nxt = flag_act_r ? `CFC_DOM_REW : 5'h00; // R14
          end else begin
            cnt_nxt = cnt_r + 5'h01;
          end
        end
        cfc_pkg::CFC_DELIM: begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == `CFC_DELIM_LAST) begin
            st_nxt  = cfc_pkg::CFC_INTER;
            cnt_nxt = 5'h00;
          end
        end
        cfc_pkg::CFC_INTER: begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == `CFC_INTER_LAST) begin
            st_nxt  = (passive && tx_r) ? cfc_pkg::CFC_SUSP
                                        : cfc_pkg::CFC_IDLE; // R10
            cnt_nxt = 5'h00;
          end
        end
        cfc_pkg::CFC_SUSP: begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == `CFC_SUSP_LAST) begin
            st_nxt = cfc_pkg::CFC_IDLE;
          end
        end
        default: begin
          st_nxt  = cfc_pkg::CFC_IDLE;
          cnt_nxt = 5'h00;
        end
      endcase
    end
  end

  assign retx_nxt = fail_tx_r & ~single_shot & (st_r != cfc_pkg::CFC_IDLE)
                  & (st_nxt == cfc_pkg::CFC_IDLE); // R6

  always_ff @(posedge clk) begin
    if (srst || !op_r) begin
      st_r       <= cfc_pkg::CFC_IDLE;
      cnt_r      <= 5'h00;
      flag_act_r <= 1'b1;
      fail_tx_r  <= 1'b0;
      tx_r       <= 1'b0;
      ackp_r     <= 1'b0;
      dom_seen_r <= 1'b0;
      first_r    <= 1'b0;
      crc_pend_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      if (crc_err && !(bit_err | stuff_err | form_err)) begin
        crc_pend_r <= 1'b1; // R5
      end else if (bit_tick && ack_delim) begin
        crc_pend_r <= 1'b0;
      end
      if (bit_tick && st_r == cfc_pkg::CFC_IDLE && (start_err || start_ovl))
      begin
        flag_act_r <= start_ovl | ~passive; // R10
        fail_tx_r  <= start_err & is_tx;
        tx_r       <= is_tx;
        ackp_r     <= ack_err & passive & is_tx; // R12
        dom_seen_r <= 1'b0;
      end else if (bit_tick && st_r == cfc_pkg::CFC_FLAG && !bus_rx) begin
        dom_seen_r <= 1'b1;
      end
      if (bit_tick) begin
        first_r <= (st_r == cfc_pkg::CFC_FLAG);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_line_output  <= 1'b1;
      err_frame_start <= 1'b0;
      retransmit_req  <= 1'b0;
      wake_event      <= 1'b0;
      prev_rx_r       <= 1'b1;
      operating_mode_status <= 1'b0;
    end else begin
      // bus-off, joining and init all keep the line recessive
      if (bus_off_flag_nxt || join_r || !op_r) begin
        tx_line_output <= 1'b1; // R17
      end else if (st_r == cfc_pkg::CFC_FLAG) begin
        tx_line_output <= ~flag_act_r; // R10
      end else if (st_r != cfc_pkg::CFC_IDLE) begin
        tx_line_output <= 1'b1;
      end else begin
        tx_line_output <= drv_bit;
      end
      err_frame_start <= start_err;
      retransmit_req  <= retx_nxt;
      wake_event      <= wake_now; // R1
      operating_mode_status <= op_r;
      if (bit_tick) begin
        prev_rx_r <= bus_rx;
      end
    end
  end

  bus_off_flag_rec_a: assert property (@(posedge clk) disable iff (srst) // R17
    bus_off_flag |-> tx_line_output && !rx_store_enable)
    else $error("bus-off without recessive output");
  tx_warn_a: assert property (@(posedge clk) disable iff (srst) // R7
    (tx_fault_counter >= 8'h60) |-> tx_warning_flag)
    else $error("transmit warning flag missing");
  rx_pass_a: assert property (@(posedge clk) disable iff (srst) // R8
    (rx_fault_counter[7] && !bus_off_flag) |-> rx_passive_flag
      && rx_warning_flag)
    else $error("receive passive flag missing");
  tec_step_a: assert property (@(posedge clk) disable iff (srst) // R12
    (tx_fault_counter > $past(tx_fault_counter)) |->
      (tx_fault_counter == $past(tx_fault_counter) + 8'h08))
    else $error("transmit counter rose by other than eight");
  tec_dec_a: assert property (@(posedge clk) disable iff (srst) // R15
    ($past(tx_ok && active_ok && !tx8 && !cc_clear && !recov_done)
      && $past(tec_r) != 8'h00) |-> (tec_r == $past(tec_r) - 8'h01))
    else $error("transmit counter did not step down");
  flag_lvl_a: assert property (@(posedge clk) disable iff (srst) // R10
    (st_r == cfc_pkg::CFC_FLAG && flag_act_r && op_r && !join_r)
      |=> (!tx_line_output || bus_off_flag))
    else $error("active error flag not dominant");
  err_now_a: assert property (@(posedge clk) disable iff (srst) // R5
    (active_ok && st_r == cfc_pkg::CFC_IDLE && bit_err) |=> err_frame_start)
    else $error("bit error did not start an error frame");
  init_ref_a: assert property (@(posedge clk) disable iff (srst) // R20
    (init_req && power_save_mode_select != cfc_pkg::CFC_PS_NONE && op_r
      && !(wake_now && bus_off_flag_r))
      |=> op_r ##1 operating_mode_status)
    else $error("init accepted in power-save mode");
  cc_init_a: assert property (@(posedge clk) disable iff (srst) // R22
    (counter_clear_request && !op_r) |=> (tx_fault_counter == 8'h00)
      && (rx_fault_counter == 8'h00) && !bus_off_flag)
    else $error("counter clear in init did not clear");
  recov_a: assert property (@(posedge clk) disable iff (srst) // R18
    (recov_done && !init_ok) |=> op_r && !bus_off_flag
      && (tx_fault_counter == 8'h00))
    else $error("recovery did not restore operation");
  single_a: assert property (@(posedge clk) disable iff (srst) // R6
    $past(single_shot) |-> !retransmit_req)
    else $error("retransmit in single-shot mode");
endmodule : cfc_fault_confinement
`default_nettype wire

// ===== src/cfc_defines.svh
// fault confinement constants: levels, field lengths, run lengths
`ifndef CFC_DEFINES_SVH
`define CFC_DEFINES_SVH
`define CFC_WARN_LVL    8'h60
`define CFC_PASS_LVL    8'h80
`define CFC_BUS_OFF_FLAG_MIN    8'hF8
`define CFC_INC8        8'h08
`define CFC_REC_LOAD    8'h7F
`define CFC_RECOV_LAST  8'h7F
`define CFC_FLAG_LAST   5'h05
`define CFC_DELIM_LAST  5'h06
`define CFC_INTER_LAST  5'h02
`define CFC_SUSP_LAST   5'h07
`define CFC_DOM_ACT     5'h0E
`define CFC_DOM_STEP    5'h08
`define CFC_DOM_REW     5'h06
`define CFC_RUN_LAST    4'hA
`define CFC_STUFF_LAST  3'h5
`endif

// ===== src/cfc_pkg.sv
// fault confinement types: error frame sequencer states, power-save modes
package cfc_pkg;
  typedef enum logic [2:0] {
    CFC_IDLE  = 3'b000,
    CFC_FLAG  = 3'b001,
    CFC_DOMW  = 3'b011,
    CFC_DELIM = 3'b010,
    CFC_INTER = 3'b110,
    CFC_SUSP  = 3'b111
  } cfc_efs_t;
  typedef enum logic [1:0] {
    CFC_PS_NONE  = 2'b00,
    CFC_PS_SLEEP = 2'b01,
    CFC_PS_STOP  = 2'b10
  } cfc_ps_t;
endpackage : cfc_pkg

// ===== src/cfc_run_detect.sv
// detector of runs of eleven consecutive recessive bits
`timescale 1ns/10ps
`default_nettype none
`include "cfc_defines.svh"
module cfc_run_detect (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic bit_tick,
  input  wire logic bus_rx,
  output logic      run_pulse
);
  logic [3:0] cnt_r;

  assign run_pulse = bit_tick & bus_rx & (cnt_r == `CFC_RUN_LAST);

  always_ff @(posedge clk) begin
    if (srst || (bit_tick && (!bus_rx || run_pulse))) begin
      cnt_r <= 4'h0;
    end else if (bit_tick) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : cfc_run_detect
`default_nettype wire

// ===== src/cfc_err_detect.sv
// detection of bit, stuff, crc, form and acknowledge errors per sampled bit
`timescale 1ns/10ps
`default_nettype none
`include "cfc_defines.svh"
module cfc_err_detect (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic bit_tick,
  input  wire logic bus_rx,
  input  wire logic drv_bit,
  input  wire logic is_tx,
  input  wire logic in_arb,
  input  wire logic in_frame,
  input  wire logic stuff_zone,
  input  wire logic crc_chk,
  input  wire logic crc_ok,
  input  wire logic form_chk,
  input  wire logic ack_slot,
  output logic      bit_err,
  output logic      stuff_err,
  output logic      crc_err,
  output logic      form_err,
  output logic      ack_err
);
  logic       last_r;
  logic [2:0] same_r;

  // losing arbitration and the transmitter's own recessive ack are no errors
  assign bit_err   = bit_tick & in_frame & (bus_rx != drv_bit)
                   & ~(in_arb & drv_bit & ~bus_rx)
                   & ~(ack_slot & is_tx); // R2
  assign stuff_err = bit_tick & stuff_zone & (bus_rx == last_r)
                   & (same_r == `CFC_STUFF_LAST); // R3
  assign crc_err   = bit_tick & crc_chk & ~crc_ok & ~is_tx; // R3
  assign form_err  = bit_tick & form_chk & ~bus_rx & ~is_tx; // R3
  assign ack_err   = bit_tick & ack_slot & is_tx & bus_rx; // R4

  always_ff @(posedge clk) begin
    if (srst) begin
      last_r <= 1'b1;
      same_r <= 3'h0;
    end else if (bit_tick) begin
      last_r <= bus_rx;
      if (!stuff_zone) begin
        same_r <= 3'h0;
      end else if (bus_rx == last_r && same_r != 3'h0) begin
        same_r <= same_r + 3'h1;
      end else begin
        same_r <= 3'h1;
      end
    end
  end
endmodule : cfc_err_detect
`default_nettype wire

// ===== sim/cfc_far_node.sv
// far-side node model: wired-and bus behind the transceiver
`timescale 1ns/10ps
`default_nettype none
module cfc_far_node (
  input  wire logic tx_line_output,
  input  wire logic other_dom,
  output logic      bus_rx
);
  // released bus sits recessive through the termination
  assign bus_rx = tx_line_output & ~other_dom;
endmodule : cfc_far_node
`default_nettype wire

// ===== sim/cfc_fault_confinement_test.sv
// self-checking bench for the fault confinement block
`timescale 1ns/10ps
`default_nettype none
module cfc_fault_confinement_test;
  logic clk = 0, srst = 1, bit_tick = 0, drv_bit = 1, is_tx = 1;
  logic in_arb = 0, stuff_zone = 0, form_chk = 0, arb_stuff_bit = 0;
  logic ovl_start = 0, in_frame = 0, crc_chk = 0, crc_ok = 1;
  logic ack_slot = 0, ack_delim = 0, single_shot = 0, other_dom = 0;
  logic init_req = 0, op_req = 0, counter_clear_request = 0;
  logic tx_ok = 0, rx_ok = 0, bus_rx;
  cfc_pkg::cfc_ps_t power_save_mode_select = cfc_pkg::CFC_PS_NONE;
  logic tx_line_output, err_frame_start, retransmit_req, wake_event;
  logic rx_store_enable, operating_mode_status, bus_off_flag;
  logic tx_warning_flag, tx_passive_flag, rx_warning_flag;
  logic rx_passive_flag, rx_passive_indicator;
  logic [7:0] tx_fault_counter, rx_fault_counter;
  logic [1:0] tcnt = 2'h0;
  int err_total = 0, num_checks = 0, efs_n = 0, rt_n = 0, wk_n = 0, n;

  cfc_fault_confinement uut (.clk, .srst, .bit_tick, .bus_rx, .drv_bit,
    .is_tx, .in_arb, .in_frame, .stuff_zone, .crc_chk, .crc_ok, .form_chk,
    .ack_slot, .ack_delim, .arb_stuff_bit, .ovl_start, .tx_ok, .rx_ok,
    .single_shot, .init_req, .op_req, .counter_clear_request,
    .power_save_mode_select, .tx_line_output, .err_frame_start,
    .retransmit_req, .wake_event, .rx_store_enable, .operating_mode_status,
    .bus_off_flag, .tx_warning_flag, .tx_passive_flag, .rx_warning_flag,
    .rx_passive_flag, .rx_passive_indicator, .tx_fault_counter,
    .rx_fault_counter);
  cfc_far_node far (.tx_line_output, .other_dom, .bus_rx);

  always #2 clk = ~clk;
  // one bit every four cycles keeps ticks two or more cycles apart
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    bit_tick <= (tcnt == 2'h3);
    if (err_frame_start === 1'b1) efs_n <= efs_n + 1;
    if (retransmit_req === 1'b1) rt_n <= rt_n + 1;
    if (wake_event === 1'b1) wk_n <= wk_n + 1;
  end

  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task st(input int k);
    repeat (k) @(posedge clk iff bit_tick);
  endtask : st
  // one dominant bit restarts the recessive run count at a known phase
  task dbit;
    st(1);
    other_dom <= 1'b1;
    st(1);
    other_dom <= 1'b0;
  endtask : dbit
  task ctl(input logic [4:0] v);
    @(posedge clk);
    {init_req, op_req, counter_clear_request, tx_ok, rx_ok} <= v;
    @(posedge clk);
    {init_req, op_req, counter_clear_request, tx_ok, rx_ok} <= 5'h00;
    repeat (3) @(negedge clk);
  endtask : ctl
  task tx_err(input logic ack);
    st(1);
    {in_frame, ack_slot, other_dom} <= {1'b1, ack, ~ack};
    st(1);
    {in_frame, ack_slot, other_dom} <= 3'h0;
  endtask : tx_err
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task rx_crc;
    @(posedge clk);
    is_tx <= 1'b0;
    st(1);
    {crc_chk, crc_ok} <= 2'b10;
    st(1);
    crc_chk <= 1'b0;
    st(2);
    chk(efs_n === 0, "crc frame too early");
    ack_delim <= 1'b1;
    st(1);
    ack_delim <= 1'b0;
    repeat (3) @(negedge clk);
    chk(efs_n === 1 && rx_fault_counter === 8'h01, "crc frame");
    st(40);
    ctl(5'h01);
    chk(rx_fault_counter === 8'h00, "rx decrement");
    @(posedge clk);
    is_tx <= 1'b1;
  endtask : rx_crc
  task tx_run;
    tx_err(1'b1);
    st(40);
    chk(tx_fault_counter === 8'h08 && rt_n === 1, "ack error");
    ctl(5'h02);
    chk(tx_fault_counter === 8'h07, "tx decrement");
    for (n = 2; n <= 32; n++) begin
      single_shot <= (n == 2);
      tx_err(1'b0);
      st(2);
      // counter reaches 128 only after the error of step 17
      chk(tx_line_output === (n > 17), "flag level");
      st(40);
      chk(tx_fault_counter === 8'(8 * n - 1), "tx count");
      chk(tx_warning_flag === (8 * n - 1 >= 96), "tx warn");
      chk(tx_passive_flag === (8 * n - 1 >= 128), "tx passive");
      chk(rt_n === n - 1, "resend count");
    end
    tx_err(1'b0);
    st(40);
    chk(bus_off_flag === 1'b1 && tx_line_output === 1'b1, "bus off");
    chk(rx_store_enable === 1'b0, "no store in bus off");
  endtask : tx_run
  task recov;
    ctl(5'h10);
    chk(operating_mode_status === 1'b0, "init ack");
    dbit();
    ctl(5'h08);
    st(11 * 20 + 2);
    chk((rx_fault_counter >= 8'h13 && rx_fault_counter <= 8'h14 &&
         operating_mode_status === 1'b0) === 1'b1, "run count");
    ctl(5'h10);
    dbit();
    ctl(5'h08);
    st(11 * 5 + 2);
    chk((rx_fault_counter >= 8'h04 && rx_fault_counter <= 8'h05 &&
         bus_off_flag === 1'b1) === 1'b1, "run restart");
    for (n = 0; n < 11 * 140 && operating_mode_status !== 1'b1; n++) st(1);
    chk(operating_mode_status === 1'b1 && n >= 11 * 120, "recovered");
    chk({bus_off_flag, tx_fault_counter, rx_fault_counter} === 17'h0_0000,
        "recovery clears");
  endtask : recov
  task clr_test;
    st(14);
    tx_err(1'b1);
    st(40);
    ctl(5'h04);
    chk(tx_fault_counter === 8'h08, "clear ignored in op");
    ctl(5'h10);
    dbit();
    ctl(5'h0C);
    chk({tx_fault_counter, tx_warning_flag} === 9'h000, "clear in init");
    chk(operating_mode_status === 1'b1, "forced start");
    n = efs_n;
    tx_err(1'b1);
    st(14);
    chk(efs_n === n && tx_fault_counter === 8'h00, "join wait");
  endtask : clr_test
  task ps_test;
    ctl(5'h08);
    st(14);
    power_save_mode_select <= cfc_pkg::CFC_PS_SLEEP;
    ctl(5'h10);
    chk(operating_mode_status === 1'b1, "init refused in sleep");
    for (n = 0; n < 2; n++) begin
      st(1);
      other_dom <= 1'b1;
      st(2);
      other_dom <= 1'b0;
      st(2);
      chk(wk_n === 1, "wake only from sleep");
      power_save_mode_select <= cfc_pkg::CFC_PS_STOP;
    end
    power_save_mode_select <= cfc_pkg::CFC_PS_NONE;
  endtask : ps_test

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk({bus_off_flag, tx_warning_flag, tx_passive_flag, rx_warning_flag,
         rx_passive_flag, rx_passive_indicator, operating_mode_status}
        === 7'h00, "reset");
    chk({tx_fault_counter, rx_fault_counter} === 16'h0000, "reset cnt");
    ctl(5'h08);
    chk(operating_mode_status === 1'b1, "operate");
    st(14);
    ctl(5'h02);
    chk(tx_fault_counter === 8'h00, "tx floor");
    rx_crc();
    tx_run();
    recov();
    clr_test();
    ps_test();
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : cfc_fault_confinement_test
`default_nettype wire
